//--- logic/hocl_protect.sv
`include "hocl_regs.svh"
module hocl_protect
   import hocl_pkg::*;
#(
   parameter int OC_EVENTS   = `HOCL_OC_EVENTS_TO_CLAMP,
   parameter int HICCUP_TC   = `HOCL_HICCUP_TERMINAL,
   parameter int CLEAN_CLEAR = `HOCL_CLEAN_CYCLES_CLEAR,
   parameter int OFF_CYCLES  = `HOCL_OFF_TIME_CYCLES
) (
   input  wire logic       mclk_i,
   input  wire logic       rst_i,            // power-up or enable toggle
   input  wire logic       uvlo_i,           // bias below undervoltage level
   input  wire logic       cycle_start_i,    // switching-cycle start pulse
   input  wire logic       pwm_i,            // modulator high-side request
   input  wire logic       shunt_limit_i,    // shunt current-limit comparator
   input  wire logic       fb_above_th_i,    // feedback above hiccup threshold
   input  wire logic       ss_done_i,        // internal soft-start complete
   input  wire logic [2:0] strap_i,          // strap level code
   input  wire logic       comp_pu_i,        // pull-up on compensation node
   input  wire logic       ext_sync_i,       // external sync clock present
   output logic            high_side_en_o,
   output logic            low_side_en_o,
   output logic            ss_pull_low_o,    // discharge soft-start node
   output logic            ss_clamp_en_o,    // clamp soft-start above feedback
   output logic            ss_restart_o,     // pulse: start new soft-start
   output logic            sync_lock_en_o,   // allow lock to external clock
   output logic            hiccup_o,         // in hiccup off-time
   output hocl_cfg_t       cfg_o
);
   //////////////////////////////////////////////////////////////////////
   // elaboration checks
   // counters are 16 bits and the clean counter 4 bits wide
   if (OC_EVENTS < 1 || OC_EVENTS > 255 || HICCUP_TC < 2 || HICCUP_TC > 65535 ||
       CLEAN_CLEAR < 1 || CLEAN_CLEAR > 15 || OFF_CYCLES < 1 || OFF_CYCLES > 65535) begin : g_bad
      $error("hocl_protect: parameter out of range");
   end

   //////////////////////////////////////////////////////////////////////
   // two-flop synchronisers for analog comparator and pin inputs
   localparam int NS = 11;
   logic [NS-1:0] sync1_reg;  // first stage, read only by second
   logic [NS-1:0] sync2_reg;  // usable samples
   always_ff @(posedge mclk_i) begin
      sync1_reg <= {cycle_start_i, pwm_i, shunt_limit_i, fb_above_th_i, ss_done_i,
                    strap_i, comp_pu_i, ext_sync_i, uvlo_i};
      sync2_reg <= sync1_reg;
   end
   hocl_sense_t sense;
   logic        uvlo_s;         // bias comparator, synchronised
   logic        pwm_s;
   logic [2:0]  strap_s;
   logic        comp_pu_s;
   logic        ext_sync_s;
   logic        cyc_prev_reg;   // edge detector on cycle start
   assign {sense.cycle_start, pwm_s, sense.shunt_limit, sense.fb_above_th, sense.ss_done,
           strap_s, comp_pu_s, ext_sync_s, uvlo_s} = sync2_reg;

   // counter bump saturating at width
   function automatic logic [15:0] bump(input logic [15:0] v);
      return (v == 16'hffff) ? v : v + 16'h0001;
   endfunction

   //////////////////////////////////////////////////////////////////////
   // configuration latch
   hocl_cfg_t cfg;
   logic      sample_pulse;
   logic      sampled_reg;      // set once the strap has been sampled after reset
   hocl_cfg_latch u_cfg (
      .mclk_i    (mclk_i),
      .rst_i     (rst_i),
      .sample_i  (sample_pulse),
      .uvlo_i    (uvlo_s),
      .strap_i   (strap_s),
      .comp_pu_i (comp_pu_s),
      .cfg_o     (cfg)
   );
   // wait for synchroniser to fill before sampling
   logic [1:0] settle_reg;
   assign sample_pulse = (settle_reg == 2'h3) && !sampled_reg;

   //////////////////////////////////////////////////////////////////////
   // state
   hocl_state_t state_reg, state_next;
   logic [15:0] oc_cnt_reg, oc_cnt_next;        // overcurrent events
   logic [15:0] hic_cnt_reg, hic_cnt_next;      // hiccup detector
   logic [3:0]  clean_reg, clean_next;          // clean cycles in a row
   logic [15:0] off_cnt_reg, off_cnt_next;      // off-time counter
   logic        clamp_reg, clamp_next;
   logic        lim_seen_reg, lim_seen_next;    // limit seen this cycle
   logic        restart_reg, restart_next;
   logic        hs_cut_reg, hs_cut_next;        // high-side cut this cycle
   logic        cyc_edge;
   logic        cycle_limited;

   assign cyc_edge      = sense.cycle_start && !cyc_prev_reg;
   assign cycle_limited = lim_seen_reg || sense.shunt_limit;

   //////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      state_next    = state_reg;
      oc_cnt_next   = oc_cnt_reg;
      hic_cnt_next  = hic_cnt_reg;
      clean_next    = clean_reg;
      off_cnt_next  = off_cnt_reg;
      clamp_next    = clamp_reg;
      lim_seen_next = lim_seen_reg;
      restart_next  = 1'b0;
      hs_cut_next   = hs_cut_reg;
      // latch the trip until the next cycle begins
      if (sense.shunt_limit) begin
         lim_seen_next = 1'b1;
         hs_cut_next   = 1'b1;
      end
      if (cyc_edge) begin
         lim_seen_next = 1'b0;
         hs_cut_next   = 1'b0;
         // count events once per limited cycle
         if (cycle_limited) begin
            oc_cnt_next = bump(oc_cnt_reg);
            if (oc_cnt_next >= 16'(OC_EVENTS)) begin
               clamp_next = 1'b1;
            end
         end
      end
      unique case (state_reg)
         HOCL_ST_SOFTSTART: begin
            hic_cnt_next = 16'h0000;
            clean_next   = 4'h0;
            if (sense.ss_done && sense.fb_above_th) begin
               state_next = HOCL_ST_RUN;
            end
         end
         HOCL_ST_RUN: begin
            if (cyc_edge) begin
               if (cycle_limited) begin
                  clean_next   = 4'h0;
                  hic_cnt_next = bump(hic_cnt_reg);
               end else begin
                  clean_next = clean_reg + 4'h1;
                  if (clean_next >= 4'(CLEAN_CLEAR)) begin
                     hic_cnt_next = 16'h0000;
                     clean_next   = 4'h0;
                  end
               end
               if (hic_cnt_next >= 16'(HICCUP_TC)) begin
                  if (sense.fb_above_th) begin
                     hic_cnt_next = 16'h0000;
                  end else begin
                     state_next   = HOCL_ST_OFF;
                     off_cnt_next = 16'h0000;
                     hic_cnt_next = 16'h0000;
                  end
               end
            end
         end
         HOCL_ST_OFF: begin
            if (cyc_edge) begin
               off_cnt_next = bump(off_cnt_reg);
               if (off_cnt_next >= 16'(OFF_CYCLES)) begin
                  state_next   = HOCL_ST_SOFTSTART;
                  restart_next = 1'b1;
               end
            end
         end
      endcase
      // a new soft-start drops event history and the clamp
      if (restart_next) begin
         oc_cnt_next = 16'h0000;
         clamp_next  = 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state_reg    <= HOCL_ST_SOFTSTART;
         oc_cnt_reg   <= 16'h0000;
         hic_cnt_reg  <= 16'h0000;
         clean_reg    <= 4'h0;
         off_cnt_reg  <= 16'h0000;
         clamp_reg    <= 1'b0;
         lim_seen_reg <= 1'b0;
         restart_reg  <= 1'b0;
         hs_cut_reg   <= 1'b0;
         // cycle start idles high at phase zero; avoids a false edge on release
         cyc_prev_reg <= 1'b1;
         settle_reg   <= 2'h0;
         sampled_reg  <= 1'b0;
      end else begin
         state_reg    <= state_next;
         oc_cnt_reg   <= oc_cnt_next;
         hic_cnt_reg  <= hic_cnt_next;
         clean_reg    <= clean_next;
         off_cnt_reg  <= off_cnt_next;
         clamp_reg    <= clamp_next;
         lim_seen_reg <= lim_seen_next;
         restart_reg  <= restart_next;
         hs_cut_reg   <= hs_cut_next;
         cyc_prev_reg <= sense.cycle_start;
         settle_reg   <= (settle_reg == 2'h3) ? settle_reg : settle_reg + 2'h1;
         sampled_reg  <= sampled_reg | sample_pulse;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // outputs; the high-side gate is gated combinationally by the synchronised
   // comparator so a trip cuts the pulse without waiting for hs_cut_reg
   assign hiccup_o       = (state_reg == HOCL_ST_OFF);
   assign high_side_en_o = pwm_s && !hs_cut_reg && !sense.shunt_limit
                           && !hiccup_o && !cfg.strap_invalid;
   assign low_side_en_o  = !pwm_s && !hiccup_o;
   assign ss_pull_low_o  = hiccup_o;
   assign ss_clamp_en_o  = clamp_reg;
   assign ss_restart_o   = restart_reg;
   // spreading forbids locking to an outside clock
   assign sync_lock_en_o = ext_sync_s && !cfg.dual_random_spreading;
   assign cfg_o          = cfg;
endmodule

//--- logic/hocl_regs.svh
`ifndef HOCL_REGS_SVH
`define HOCL_REGS_SVH
// overcurrent events needed before the soft-start clamp engages
`define HOCL_OC_EVENTS_TO_CLAMP   16
// hiccup detector terminal count, in limited cycles
`define HOCL_HICCUP_TERMINAL      512
// clean cycles in a row that clear the hiccup detector
`define HOCL_CLEAN_CYCLES_CLEAR   4
// hiccup off-time, in switching cycles
`define HOCL_OFF_TIME_CYCLES      16384
// strap level codes from the analog level detector
`define HOCL_STRAP_SA_NOSPREAD    3'h0
`define HOCL_STRAP_SA_SPREAD      3'h1
`define HOCL_STRAP_PRI_NOSPREAD   3'h2
`define HOCL_STRAP_PRI_SPREAD     3'h3
`define HOCL_STRAP_SECONDARY      3'h4
`endif

//--- logic/hocl_pkg.sv
package hocl_pkg;
   // role of this device in a paralleled pair
   typedef enum logic [1:0] {
      HOCL_ROLE_STANDALONE = 2'h0,
      HOCL_ROLE_PRIMARY    = 2'h1,
      HOCL_ROLE_SECONDARY  = 2'h2
   } hocl_role_t;

   // latched start-up configuration
   typedef struct packed {
      hocl_role_t role;
      logic       dual_random_spreading;
      logic       internal_comp;
      logic       strap_invalid;
   } hocl_cfg_t;

   // comparator inputs, already synchronised
   typedef struct packed {
      logic cycle_start;    // one pulse per switching cycle
      logic shunt_limit;    // shunt current-limit comparator
      logic fb_above_th;    // feedback above hiccup threshold
      logic ss_done;        // internal soft-start complete
   } hocl_sense_t;

   // drive outputs to power stage and soft-start node
   typedef struct packed {
      logic high_side_en;
      logic low_side_en;
      logic ss_pull_low;
      logic ss_clamp_en;
      logic ss_restart;
   } hocl_drive_t;

   // hiccup controller states
   typedef enum logic [2:0] {
      HOCL_ST_SOFTSTART = 3'b001,
      HOCL_ST_RUN       = 3'b010,
      HOCL_ST_OFF       = 3'b100
   } hocl_state_t;
endpackage

//--- logic/hocl_cfg_latch.sv
`include "hocl_regs.svh"
// start-up latch of strap and compensation detection
module hocl_cfg_latch
   import hocl_pkg::*;
(
   input  wire logic      mclk_i,
   input  wire logic      rst_i,
   input  wire logic      sample_i,     // pulse: sample strap now
   input  wire logic      uvlo_i,       // bias below undervoltage level
   input  wire logic [2:0] strap_i,     // synchronised strap level code
   input  wire logic      comp_pu_i,    // pull-up seen on compensation node
   output hocl_cfg_t      cfg_o
);
   logic       taken_reg;       // strap sampled since last start
   logic       taken_next;
   logic       comp_taken_reg;  // comp detected since last uvlo
   logic       comp_taken_next;
   hocl_cfg_t  cfg_reg;
   hocl_cfg_t  cfg_next;

   //////////////////////////////////////////////////////////////////////
   // next-state: strap once per enable, compensation once per uvlo
   always_comb begin
      taken_next      = taken_reg;
      comp_taken_next = comp_taken_reg;
      cfg_next        = cfg_reg;
      if (sample_i && !taken_reg) begin
         taken_next             = 1'b1;
         cfg_next.strap_invalid = 1'b0;
         unique case (strap_i)
            `HOCL_STRAP_SA_NOSPREAD: begin
               cfg_next.role = HOCL_ROLE_STANDALONE;
               cfg_next.dual_random_spreading = 1'b0;
            end
            `HOCL_STRAP_SA_SPREAD: begin
               cfg_next.role = HOCL_ROLE_STANDALONE;
               cfg_next.dual_random_spreading = 1'b1;
            end
            `HOCL_STRAP_PRI_NOSPREAD: begin
               cfg_next.role = HOCL_ROLE_PRIMARY;
               cfg_next.dual_random_spreading = 1'b0;
            end
            `HOCL_STRAP_PRI_SPREAD: begin
               cfg_next.role = HOCL_ROLE_PRIMARY;
               cfg_next.dual_random_spreading = 1'b1;
            end
            `HOCL_STRAP_SECONDARY: begin
               // spreading has no meaning on a secondary
               cfg_next.role = HOCL_ROLE_SECONDARY;
               cfg_next.dual_random_spreading = 1'b0;
            end
            default: begin
               // unknown level: safest is standalone, no spreading
               cfg_next.role = HOCL_ROLE_STANDALONE;
               cfg_next.dual_random_spreading = 1'b0;
               cfg_next.strap_invalid = 1'b1;
            end
         endcase
      end
      if (sample_i && !comp_taken_reg) begin
         comp_taken_next        = 1'b1;
         cfg_next.internal_comp = comp_pu_i;
      end
      // only a bias collapse re-arms the compensation detector
      if (uvlo_i) begin
         comp_taken_next = 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // registers; rst_i is power-up or enable toggle, so the strap re-arms
   // there while the compensation choice survives it
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         taken_reg <= 1'b0;
         cfg_reg.role <= HOCL_ROLE_STANDALONE;
         cfg_reg.dual_random_spreading <= 1'b0;
         cfg_reg.strap_invalid <= 1'b0;
         comp_taken_reg <= uvlo_i ? 1'b0 : comp_taken_next;
         cfg_reg.internal_comp <= cfg_next.internal_comp;
      end else begin
         taken_reg      <= taken_next;
         comp_taken_reg <= comp_taken_next;
         cfg_reg        <= cfg_next;
      end
   end

   assign cfg_o = cfg_reg;
endmodule

//--- test/hocl_sva.sv
module hocl_sva
   import hocl_pkg::*;
(
   input  wire logic      mclk_i,
   input  wire logic      rst_i,
   input  wire logic      shunt_limit_i,
   input  wire logic      fb_above_th_i,
   input  wire logic      high_side_en_o,
   input  wire logic      low_side_en_o,
   input  wire logic      ss_pull_low_o,
   input  wire logic      ss_clamp_en_o,
   input  wire logic      ss_restart_o,
   input  wire logic      sync_lock_en_o,
   input  wire logic      hiccup_o,
   input  wire hocl_cfg_t cfg_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////
   logic [3:0] age_reg;   // edges since reset release, saturating
   logic [3:0] age_next;
   // the strap is sampled a few edges after release, so wait it out first
   always_comb age_next = rst_i ? 4'h0 : age_reg + {3'h0, ~&age_reg};
   always_ff @(posedge mclk_i) age_reg <= age_next;
   ////////////////////////////////////////////////////////////////////////////
   // pin sampled two edges back reaches the gate through the synchroniser
   cut_on_limit_a: assert property ($past(shunt_limit_i, 2) |-> !high_side_en_o)
      else $error("high side on during current limit");
   drivers_off_a: assert property (hiccup_o |-> !high_side_en_o && !low_side_en_o)
      else $error("driver on during hiccup");
   pull_low_a: assert property (ss_pull_low_o == hiccup_o)
      else $error("soft-start pull-low differs from hiccup");
   low_fb_entry_a: assert property ($rose(hiccup_o) |-> !$past(fb_above_th_i, 3))
      else $error("hiccup entered with high feedback");
   off_hold_a: assert property ($rose(hiccup_o) |-> hiccup_o [*8])
      else $error("hiccup off-time cut short");
   restart_after_a: assert property ($fell(hiccup_o) |-> ##[0:1] ss_restart_o)
      else $error("no soft-start restart after off-time");
   clamp_release_a: assert property (ss_restart_o |-> ##[0:1] !ss_clamp_en_o)
      else $error("clamp kept over a new soft-start");
   no_sync_spread_a: assert property (sync_lock_en_o |-> !cfg_o.dual_random_spreading)
      else $error("sync lock while spreading");
   cfg_frozen_a: assert property (age_reg == 4'hf |-> $stable(cfg_o))
      else $error("configuration changed after sampling");
endmodule

bind hocl_protect hocl_sva hocl_sva_i (.mclk_i, .rst_i, .shunt_limit_i, .fb_above_th_i,
   .high_side_en_o, .low_side_en_o, .ss_pull_low_o, .ss_clamp_en_o, .ss_restart_o,
   .sync_lock_en_o, .hiccup_o, .cfg_o);

//--- test/hocl_plant.sv
// comparators, modulator and soft-start node seen by the protection block
module hocl_plant
   import hocl_pkg::*;
(
   input  wire logic   mclk_i,
   input  wire logic   rst_i,
   input  wire logic   overload_i,   // inductor current beyond the limit
   input  wire logic   fb_hi_i,      // output above the hiccup threshold
   input  wire logic   ss_reset_i,   // soft-start node discharged or restarted
   output logic        pwm_o,        // modulator high-side request
   output hocl_sense_t sense_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] phase_reg = 3'h0;   // position in an eight-clock switching cycle
   logic [4:0] ss_reg    = 5'h00;  // soft-start ramp progress
   ////////////////////////////////////////////////////////////////////////////
   // changes on the falling edge, like the rest of the stimulus
   always @(negedge mclk_i) begin
      phase_reg <= rst_i ? 3'h0 : phase_reg + 3'h1;
      ss_reg <= (rst_i || ss_reset_i) ? 5'h00 : ss_reg + {4'h0, ~&ss_reg};
   end
   // trip only while the ramp is up, as a real shunt would
   always_comb begin
      pwm_o = phase_reg < 3'h5;
      sense_o.cycle_start = phase_reg == 3'h0;
      sense_o.shunt_limit = overload_i && (phase_reg inside {[3'h1:3'h4]});
      sense_o.fb_above_th = fb_hi_i;
      sense_o.ss_done = &ss_reg;
   end
endmodule

//--- test/testbench.sv
module testbench
   import hocl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        uvlo = 1'b1;
   logic        overload = 1'b0;
   logic        fb_hi = 1'b1;
   logic        ext_sync = 1'b1;
   logic [2:0]  strap = 3'h0;
   logic        comp_pu = 1'b1;
   logic        pwm;
   hocl_sense_t sense;
   logic        high_side, low_side, pull_low, clamp, restart, sync_lock, hiccup;
   hocl_cfg_t   cfg;
   int          n_fail = 0;
   int          checked = 0;
   ////////////////////////////////////////////////////////////////////////////
   // short counts keep the run brief
   hocl_protect #(.OC_EVENTS(4), .HICCUP_TC(8), .CLEAN_CLEAR(4), .OFF_CYCLES(16)) hocl_protect_i (
      .mclk_i(mclk), .rst_i(rst), .uvlo_i(uvlo), .cycle_start_i(sense.cycle_start),
      .pwm_i(pwm), .shunt_limit_i(sense.shunt_limit), .fb_above_th_i(sense.fb_above_th),
      .ss_done_i(sense.ss_done), .strap_i(strap), .comp_pu_i(comp_pu),
      .ext_sync_i(ext_sync), .high_side_en_o(high_side), .low_side_en_o(low_side),
      .ss_pull_low_o(pull_low), .ss_clamp_en_o(clamp), .ss_restart_o(restart),
      .sync_lock_en_o(sync_lock), .hiccup_o(hiccup), .cfg_o(cfg));
   hocl_plant hocl_plant_i (.mclk_i(mclk), .rst_i(rst), .overload_i(overload),
      .fb_hi_i(fb_hi), .ss_reset_i(restart | pull_low), .pwm_o(pwm), .sense_o(sense));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #4 mclk = ~mclk;
   end
   task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // reset with a given strap, pull-up and bias level, then let it settle
   task automatic reboot(input logic [2:0] code, input logic pu, input logic uv);
      @(negedge mclk);
      rst = 1'b1;
      strap = code;
      comp_pu = pu;
      uvlo = uv;
      repeat (10) @(negedge mclk);
      rst = 1'b0;
      uvlo = 1'b0;
      repeat (40) @(negedge mclk);
   endtask
   // wait for n switching cycles plus the synchroniser delay
   task automatic cyc(input int n);
      repeat (n) @(posedge sense.cycle_start);
      repeat (4) @(negedge mclk);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      // each decoded strap code, 0 to 4, with an external clock present
      for (int i = 0; i < 5; i++) begin
         reboot(3'(i), 1'b1, 1'b1);
         chk(cfg.role, 2'(i / 2));
         if (i < 4) begin
            chk(2'(cfg.dual_random_spreading), 2'(i % 2));
            chk(2'(sync_lock), 2'(i % 2 == 0));
         end
      end
      strap = 3'h0;
      cyc(2);
      chk(cfg.role, 2'h2);
      chk(2'(cfg.internal_comp), 2'h1);
      reboot(3'h0, 1'b0, 1'b0);
      chk(2'(cfg.internal_comp), 2'h1);
      reboot(3'h0, 1'b0, 1'b1);
      chk(2'(cfg.internal_comp), 2'h0);
      // an undecoded strap level falls back to standalone with high side held off
      reboot(3'h7, 1'b0, 1'b0);
      chk(2'(cfg.strap_invalid), 2'h1);
      chk(cfg.role, 2'h0);
      chk(2'(high_side), 2'h0);
      // a valid standalone strap clears the invalid flag again
      reboot(3'h0, 1'b0, 1'b0);
      chk(2'(cfg.strap_invalid), 2'h0);
      $display("test config done");
      // overload with feedback high: limit, clamp, no hiccup
      @(posedge sense.cycle_start);
      overload = 1'b1;
      @(posedge sense.shunt_limit);
      repeat (3) @(negedge mclk);
      chk(2'(high_side), 2'h0);
      cyc(2);
      chk(2'(clamp), 2'h0);
      cyc(4);
      chk(2'(clamp), 2'h1);
      cyc(14);
      chk(2'(hiccup), 2'h0);
      $display("test limit done");
      // bursts split by clean cycles never reach the terminal count
      overload = 1'b0;
      fb_hi = 1'b0;
      cyc(6);
      overload = 1'b1;
      cyc(5);
      overload = 1'b0;
      cyc(6);
      overload = 1'b1;
      cyc(5);
      chk(2'(hiccup), 2'h0);
      cyc(6);
      chk(2'(hiccup), 2'h1);
      chk({high_side, low_side}, 2'h0);
      chk(2'(pull_low), 2'h1);
      overload = 1'b0;
      cyc(10);
      chk(2'(hiccup), 2'h1);
      cyc(6);
      chk(2'(hiccup), 2'h0);
      chk(2'(clamp), 2'h0);
      // low feedback after restart keeps hiccup away despite overload
      overload = 1'b1;
      cyc(20);
      chk(2'(hiccup), 2'h0);
      $display("test hiccup done");
      results();
   end
   // the whole sequence needs about 1200 clocks
   initial begin
      #200_000;
      n_fail++;
      results();
   end
endmodule
